// ### pwm_irq_pkg.sv
// Purpose: shared constants for the pwm interrupt status and clear block
// Assumes: 32-bit avalon-mm register bus, byte addresses
// Notes: source bit order follows the status word, timer stop at bit 0
package pwm_irq_pkg;
    localparam int unsigned NUM_SRC  = 30;
    localparam int unsigned ADDR_W   = 12;
    localparam int unsigned DATA_W   = 32;

    localparam logic [11:0] RAW_OFFSET    = 12'h110;
    localparam logic [11:0] ENA_OFFSET    = 12'h114;
    localparam logic [11:0] MASKED_OFFSET = 12'h118;
    localparam logic [11:0] CLEAR_OFFSET  = 12'h11c;

    localparam logic [29:0] ENA_RESET = 30'h0000_0000;
    localparam logic [29:0] RAW_RESET = 30'h0000_0000;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    // bit positions of each group of three sources
    localparam int unsigned TIMER_STOP_LSB = 0;
    localparam int unsigned TIMER_ZERO_LSB = 3;
    localparam int unsigned TIMER_PER_LSB  = 6;
    localparam int unsigned FAULT_BEG_LSB  = 9;
    localparam int unsigned FAULT_END_LSB  = 12;
    localparam int unsigned CMP_A_LSB      = 15;
    localparam int unsigned CMP_B_LSB      = 18;
    localparam int unsigned CBC_LSB        = 21;
    localparam int unsigned OST_LSB        = 24;
    localparam int unsigned CAPTURE_LSB    = 27;
endpackage

// ### irq_flag_bank.sv
// Purpose: sticky raw interrupt flags, set by events, cleared by one-writes
// Assumes: events and clear are one-cycle pulses on ref_clk_i
// Notes: a set in the clearing cycle keeps the flag high
`timescale 1ns/1ps
module irq_flag_bank #(
    parameter int unsigned WIDTH = 30
) (
    input  wire logic             ref_clk_i,
    input  wire logic             rstn_i,
    input  wire logic [WIDTH-1:0] set_i,
    input  wire logic [WIDTH-1:0] clr_i,
    output logic      [WIDTH-1:0] flag_o
);
    typedef struct packed {
        logic [WIDTH-1:0] flag;
    } state_s;

    state_s state_q;
    state_s state_d;

    always_comb begin
        state_d      = state_q;
        state_d.flag = (state_q.flag & ~clr_i) | set_i;
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign flag_o = state_q.flag;
endmodule // irq_flag_bank

// ### irq_source_map.sv
// Purpose: packs the grouped event pulses into one source vector
// Assumes: each group input is three bits, index = unit number
// Notes: pure wiring, combinational
`timescale 1ns/1ps
module irq_source_map (
    input  wire logic [2:0]  timer_stop_i,
    input  wire logic [2:0]  timer_at_zero_event_i,
    input  wire logic [2:0]  timer_at_period_event_i,
    input  wire logic [2:0]  fault_begin_i,
    input  wire logic [2:0]  fault_end_i,
    input  wire logic [2:0]  operator_compare_a_event_i,
    input  wire logic [2:0]  operator_compare_b_event_i,
    input  wire logic [2:0]  cycle_by_cycle_trip_i,
    input  wire logic [2:0]  one_shot_trip_i,
    input  wire logic [2:0]  capture_event_i,
    output logic      [29:0] src_o
);
    always_comb begin
        src_o = '0;
        src_o[pwm_irq_pkg::TIMER_STOP_LSB +: 3] = timer_stop_i;
        src_o[pwm_irq_pkg::TIMER_ZERO_LSB +: 3] = timer_at_zero_event_i;
        src_o[pwm_irq_pkg::TIMER_PER_LSB  +: 3] = timer_at_period_event_i;
        src_o[pwm_irq_pkg::FAULT_BEG_LSB  +: 3] = fault_begin_i;
        src_o[pwm_irq_pkg::FAULT_END_LSB  +: 3] = fault_end_i;
        src_o[pwm_irq_pkg::CMP_A_LSB      +: 3] = operator_compare_a_event_i;
        src_o[pwm_irq_pkg::CMP_B_LSB      +: 3] = operator_compare_b_event_i;
        src_o[pwm_irq_pkg::CBC_LSB        +: 3] = cycle_by_cycle_trip_i;
        src_o[pwm_irq_pkg::OST_LSB        +: 3] = one_shot_trip_i;
        src_o[pwm_irq_pkg::CAPTURE_LSB    +: 3] = capture_event_i;
    end
endmodule // irq_source_map

// ### pwm_irq_status_clear.sv
// Purpose: interrupt status, enable and clear registers of a pwm unit
// Assumes: avalon-mm slave, one wait cycle on every access
// Notes: irq_o is high while any enabled raw flag is set
`timescale 1ns/1ps
module pwm_irq_status_clear #(
    parameter int unsigned NUM_SRC = pwm_irq_pkg::NUM_SRC
) (
    input  wire logic        ref_clk_i,
    input  wire logic        rstn_i,
    input  wire logic [11:0] avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    output logic      [1:0]  avs_response_o,
    input  wire logic [2:0]  timer_stop_i,
    input  wire logic [2:0]  timer_at_zero_event_i,
    input  wire logic [2:0]  timer_at_period_event_i,
    input  wire logic [2:0]  fault_begin_i,
    input  wire logic [2:0]  fault_end_i,
    input  wire logic [2:0]  operator_compare_a_event_i,
    input  wire logic [2:0]  operator_compare_b_event_i,
    input  wire logic [2:0]  cycle_by_cycle_trip_i,
    input  wire logic [2:0]  one_shot_trip_i,
    input  wire logic [2:0]  capture_event_i,
    output logic             irq_o
);
    localparam logic [1:0] RESP_OK  = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;

    typedef struct packed {
        logic [NUM_SRC-1:0] ena;
        logic               waitreq;
        logic [31:0]        rdata;
        logic [1:0]         resp;
        logic               irq;
    } state_s;

    state_s state_q;
    state_s state_d;

    logic [NUM_SRC-1:0] src;
    logic [NUM_SRC-1:0] raw;
    logic [NUM_SRC-1:0] clr;

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] widen(input logic [NUM_SRC-1:0] v);
        logic [31:0] r;
        r = pwm_irq_pkg::READ_ZERO;
        r[NUM_SRC-1:0] = v;
        return r;
    endfunction

    irq_source_map u_map (
        .timer_stop_i               (timer_stop_i),
        .timer_at_zero_event_i      (timer_at_zero_event_i),
        .timer_at_period_event_i    (timer_at_period_event_i),
        .fault_begin_i              (fault_begin_i),
        .fault_end_i                (fault_end_i),
        .operator_compare_a_event_i (operator_compare_a_event_i),
        .operator_compare_b_event_i (operator_compare_b_event_i),
        .cycle_by_cycle_trip_i      (cycle_by_cycle_trip_i),
        .one_shot_trip_i            (one_shot_trip_i),
        .capture_event_i            (capture_event_i),
        .src_o                      (src)
    );

    irq_flag_bank #(.WIDTH(NUM_SRC)) u_flags (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .set_i     (src),
        .clr_i     (clr),
        .flag_o    (raw)
    );

    logic        req;
    logic        take;
    logic [31:0] clr_word;

    always_comb begin
        req      = avs_read_i | avs_write_i;
        take     = req & state_q.waitreq;
        clr_word = merge_bytes(pwm_irq_pkg::READ_ZERO, avs_writedata_i, avs_byteenable_i);
        clr      = '0;
        if (take && avs_write_i && avs_address_i == pwm_irq_pkg::CLEAR_OFFSET) begin
            clr = clr_word[NUM_SRC-1:0];
        end
    end

    always_comb begin
        state_d       = state_q;
        state_d.waitreq = ~take;
        state_d.rdata = pwm_irq_pkg::READ_ZERO;
        state_d.resp  = RESP_OK;
        if (take) begin
            case (avs_address_i)
                pwm_irq_pkg::RAW_OFFSET: begin
                    state_d.rdata = avs_read_i ? widen(raw) : pwm_irq_pkg::READ_ZERO;
                end
                pwm_irq_pkg::ENA_OFFSET: begin
                    if (avs_write_i) begin
                        state_d.ena = NUM_SRC'(merge_bytes(widen(state_q.ena),
                                                           avs_writedata_i,
                                                           avs_byteenable_i));
                    end else begin
                        state_d.rdata = widen(state_q.ena);
                    end
                end
                pwm_irq_pkg::MASKED_OFFSET: begin
                    // write ignored, read-only word
                    state_d.rdata = avs_read_i ? widen(raw & state_q.ena)
                                               : pwm_irq_pkg::READ_ZERO;
                end
                pwm_irq_pkg::CLEAR_OFFSET: begin
                    state_d.rdata = pwm_irq_pkg::READ_ZERO;
                end
                default: begin
                    state_d.resp = RESP_ERR;
                end
            endcase
        end
        // irq uses the flag and enable values loaded this edge, so it changes on the same edge; includes same-cycle set over clear
        state_d.irq = |(((raw & ~clr) | src) & state_d.ena);
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q       <= '0;
            state_q.ena   <= pwm_irq_pkg::ENA_RESET;
            // idle slave shows waitrequest high straight from the flop
            state_q.waitreq <= 1'b1;
        end else begin
            state_q <= state_d;
        end
    end

    assign avs_readdata_o    = state_q.rdata;
    assign avs_waitrequest_o = state_q.waitreq;
    assign avs_response_o    = state_q.resp;
    assign irq_o             = state_q.irq;
endmodule // pwm_irq_status_clear

// ### pwm_irq_props.sv
// Purpose: bus and interrupt timing checks
// Assumes: one wait cycle per access
// Notes: bound to the top module
`timescale 1ns/1ps
module pwm_irq_chk (
    input wire logic        ref_clk_i,
    input wire logic        rstn_i,
    input wire logic [11:0] avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic [1:0]  avs_response_o,
    input wire logic        irq_o
);
    logic taken;
    logic mapped;
    assign taken  = (avs_read_i | avs_write_i) & avs_waitrequest_o;
    assign mapped = avs_address_i inside {12'h110, 12'h114, 12'h118, 12'h11c};
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    chk_answer_next: assert property (taken |=> !avs_waitrequest_o)
        else $error("no answer after request");
    chk_answer_short: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("answer held too long");
    chk_unmapped_err: assert property (taken && !mapped |=> avs_response_o == 2'h2)
        else $error("unmapped access not refused");
    chk_mapped_ok: assert property (taken && mapped |=> avs_response_o == 2'h0)
        else $error("mapped access refused");
    chk_clear_wo: assert property (taken && avs_read_i && avs_address_i == 12'h11c
        |=> avs_readdata_o == 32'h0)
        else $error("clear word read not zero");
    chk_top_bits: assert property (!avs_waitrequest_o |-> avs_readdata_o[31:30] == 2'h0)
        else $error("unused bits set");
    chk_irq_fall: assert property ($fell(irq_o) |-> $past(avs_write_i) || $past(avs_write_i, 2))
        else $error("irq fell without write");
    chk_irq_sticky: assert property (irq_o && !avs_write_i && !$past(avs_write_i) |=> irq_o)
        else $error("irq dropped by itself");
    cover property (taken && !mapped);
    cover property ($rose(irq_o));
    cover property (taken && avs_write_i && avs_address_i == 12'h11c);
endmodule // pwm_irq_chk
bind pwm_irq_status_clear pwm_irq_chk pwm_irq_chk_i (.*);

// ### test_pwm_irq_status_clear.sv
// Purpose: register level test of the interrupt block
// Assumes: one access at a time
// Notes: events are one-cycle pulses
`timescale 1ns/1ps
module test_pwm_irq_status_clear;
    logic ref_clk_i, rstn_i, avs_read_i, avs_write_i, avs_waitrequest_o, irq_o;
    logic [11:0] avs_address_i;
    logic [31:0] avs_writedata_i, avs_readdata_o, q;
    logic [3:0] avs_byteenable_i;
    logic [1:0] avs_response_o, r;
    logic [2:0] timer_stop_i, timer_at_zero_event_i, timer_at_period_event_i, fault_begin_i;
    logic [2:0] fault_end_i, operator_compare_a_event_i, operator_compare_b_event_i;
    logic [2:0] cycle_by_cycle_trip_i, one_shot_trip_i, capture_event_i;
    int mismatches, comparisons;
    pwm_irq_status_clear pwm_irq_status_clear_i (.*);
    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        {avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} <= {!w, w, a, d};
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 50);
        if (n >= 50) begin
            mismatches++;
            finish_test;
        end
        q = avs_readdata_o;
        r = avs_response_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask
    task automatic ev(input logic [29:0] m);
        {capture_event_i, one_shot_trip_i, cycle_by_cycle_trip_i, operator_compare_b_event_i,
         operator_compare_a_event_i, fault_end_i, fault_begin_i, timer_at_period_event_i,
         timer_at_zero_event_i, timer_stop_i} <= m;
    endtask
    task automatic pulse(input logic [29:0] m);
        @(posedge ref_clk_i);
        ev(m);
        @(posedge ref_clk_i);
        ev(30'h0);
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #500000;
        mismatches++;
        finish_test;
    end
    initial begin
        {rstn_i, avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} = '0;
        avs_byteenable_i = 4'hf;
        ev(30'h0);
        repeat (10) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            acc(0, 12'h110 + 12'(4 * i), 32'h0);
            chk("reset_word", q, 32'h0);
        end
        $display("test reset done");
        acc(1, 12'h114, 32'h3fffffff);
        for (int i = 0; i < 30; i++) begin
            pulse(30'h1 << i);
            acc(0, 12'h118, 32'h0);
            chk("masked_bit", q, 32'h1 << i);
            chk("irq_set", {31'h0, irq_o}, 32'h1);
            acc(1, 12'h11c, 32'h0);
            acc(0, 12'h118, 32'h0);
            chk("zero_clear", q, 32'h1 << i);
            acc(1, 12'h11c, 32'h1 << i);
            acc(0, 12'h118, 32'h0);
            chk("cleared", q, 32'h0);
            chk("irq_clr", {31'h0, irq_o}, 32'h0);
        end
        $display("test sources done");
        acc(1, 12'h114, 32'h2aaaaaaa);
        pulse(30'h3fffffff);
        acc(1, 12'h118, 32'hffffffff);
        acc(0, 12'h118, 32'h0);
        chk("mask", q, 32'h2aaaaaaa);
        acc(0, 12'h110, 32'h0);
        chk("raw", q, 32'h3fffffff);
        acc(0, 12'h11c, 32'h0);
        chk("clear_read", q, 32'h0);
        acc(1, 12'h114, 32'h0);
        acc(0, 12'h118, 32'h0);
        chk("irq_masked", {31'h0, irq_o}, 32'h0);
        acc(1, 12'h11c, 32'hffffffff);
        $display("test mask done");
        pulse(30'h08000000);
        fork
            acc(1, 12'h11c, 32'h08000000);
            pulse(30'h08000000);
        join
        acc(0, 12'h110, 32'h0);
        chk("set_wins", q, 32'h08000000);
        avs_byteenable_i <= 4'h7;
        acc(1, 12'h11c, 32'h08000000);
        acc(0, 12'h110, 32'h0);
        chk("lane_off", q, 32'h08000000);
        avs_byteenable_i <= 4'hf;
        acc(0, 12'h120, 32'h0);
        chk("unmapped", {30'h0, r}, 32'h2);
        acc(1, 12'h124, 32'h0);
        chk("unmapped_wr", {30'h0, r}, 32'h2);
        $display("test priority and errors done");
        acc(1, 12'h114, 32'h3fffffff);
        chk("irq_pending", {31'h0, irq_o}, 32'h1);
        rstn_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        chk("irq_reset", {31'h0, irq_o}, 32'h0);
        rstn_i <= 1'b1;
        acc(0, 12'h110, 32'h0);
        chk("raw_reset", q, 32'h0);
        acc(0, 12'h114, 32'h0);
        chk("ena_reset", q, 32'h0);
        $display("test reset in run done");
        finish_test;
    end
endmodule // test_pwm_irq_status_clear
